// File: verilog/ied_dispatch.sv
// Interrupt and exception dispatch: vectors, gate fetch, state push and return.
//
// Functional notes
// - Interrupts asynchronous; exceptions fault, trap or abort.
// - Halt program; locate handler by vector entry.
// - Vectors 0-8, 10-14, 16-20 are predefined.
// - Vectors 32-255 for software-defined interrupts.
// - Implicit call to handler procedure or task.
// - Procedure entry is interrupt or trap gate.
// - Gate gives rights, selector and offset.
// - Interrupt gate clears interrupt enable flag.
// - Trap gate leaves interrupt enable unchanged.
// - Divide error uses vector 0.
// - Debug 1, NMI 2, breakpoint 3, overflow 4.
// - Bounds 5, invalid opcode 6, no coprocessor 7.
// - Double fault uses vector 8.
// - Vectors 9, 15, 21-31 never generated.
// - Task state 10, segment absent 11, stack 12.
// - Protection 13, paging fault 14.
// - Math fault 16, alignment check 17.
// - Machine check 18, SIMD 19, virtualization 20.
// - External pin or software instruction use 32-255; only the software vector is checked, the pin vector is taken as given.
// - System management interrupt bypasses the table.
// - Return resumes interrupted program at its point.
// - Push flags, selector, pointer, then error code.
// - More privileged handler switches stack first.
// - Handler return restores selector, pointer and flags.
`timescale 1ns/1ps
`include "ied_defines.svh"
module ied_dispatch #(
    parameter int EXC_N = 18,
    parameter int ADDR_W = 32
) (
    input wire logic clk,
    input wire logic sys_rst,
    // External sources, asynchronous to the core clock.
    input wire logic external_irq_pin,
    input wire logic [7:0] external_irq_vector,
    input wire logic nmi_pin,
    input wire logic system_management_interrupt,
    // Pipeline side.
    input wire logic [EXC_N-1:0] exc_req,
    input wire ied_pkg::ied_class_t exc_class,
    input wire logic [31:0] exc_error_code,
    input wire logic exc_has_error,
    input wire logic soft_int_req,
    input wire logic [7:0] soft_int_vector,
    input wire logic handler_return_instruction,
    input wire logic [1:0] current_priv,
    input wire logic [31:0] cur_instruction_pointer,
    input wire logic [15:0] cur_code_selector,
    input wire logic [15:0] cur_stack_selector,
    input wire logic [31:0] cur_stack_pointer,
    input wire logic [31:0] priv_stack_pointer,
    input wire logic [15:0] priv_stack_selector,
    // Flags register load from software.
    input wire logic flags_wr_en,
    input wire logic [31:0] flags_wr_data,
    // Table load port.
    input wire logic table_wr_en,
    input wire logic [7:0] table_wr_idx,
    input wire logic [63:0] table_wr_data,
    // Stack pop data for the return sequence.
    input wire logic [31:0] pop_data,
    // Outputs.
    output logic pipeline_halt,
    output logic [7:0] taken_vector,
    output ied_pkg::ied_class_t taken_class,
    output logic task_switch_req,
    output logic smm_entry,
    output logic push_valid,
    output logic [31:0] push_data,
    output logic pop_req,
    output logic [ADDR_W-1:0] stack_pointer_q,
    output logic [15:0] stack_selector_q,
    output logic [15:0] code_selector_q,
    output logic [31:0] instruction_pointer_q,
    output logic [31:0] flags_register_q,
    output logic redirect,
    output logic reserved_vector_err
);
    import ied_pkg::*;

    // --------------------------------------------------------------
    // Types and state.
    // --------------------------------------------------------------
    typedef enum logic [3:0] {
        IED_IDLE, IED_FETCH, IED_DECODE, IED_PUSH_SS, IED_PUSH_SP, IED_PUSH_FL,
        IED_PUSH_CS, IED_PUSH_IP, IED_PUSH_ERR, IED_LOAD, IED_POP_IP, IED_POP_CS,
        IED_POP_FL, IED_POP_SP, IED_POP_SS
    } ied_state_t;

    ied_state_t state_q; // Sequencer state.
    logic [7:0] vec_q; // Vector of the event in service.
    ied_class_t cls_q; // Class of the event in service.
    logic [31:0] err_q; // Error code captured with the event.
    logic err_v_q; // Error code must be pushed.
    logic switch_q; // A stack switch is under way.
    logic [31:0] sv_fl_q; // Flags saved before the gate acts.
    logic [31:0] sv_ip_q; // Pointer saved for the push.
    logic [15:0] sv_cs_q; // Code selector saved for the push.
    logic [31:0] sv_sp_q; // Old stack pointer saved for the push.
    logic [15:0] sv_ss_q; // Old stack selector saved for the push.
    logic [63:0] gate_q; // Fetched entry, kept for the load step.
    logic [63:0] tbl_rd; // Registered table read data.
    logic ret_chg_q; // Return crosses privilege, pop stack too.

    // --------------------------------------------------------------
    // Pin synchronisers.
    // --------------------------------------------------------------
    // Three stages per pin; a level counts once stages two and three agree.
    logic [2:0] irq_s, nmi_s, smi_s;
    logic irq_lvl_q, nmi_lvl_q, nmi_prev_q, smi_lvl_q, smi_prev_q;
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            irq_s <= 3'h0;
            nmi_s <= 3'h0;
            smi_s <= 3'h0;
        end else begin
            irq_s <= {irq_s[1:0], external_irq_pin};
            nmi_s <= {nmi_s[1:0], nmi_pin};
            smi_s <= {smi_s[1:0], system_management_interrupt};
        end
    end

    // Filtered levels; stage one is never looked at here.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            irq_lvl_q <= 1'b0;
            nmi_lvl_q <= 1'b0;
            smi_lvl_q <= 1'b0;
            nmi_prev_q <= 1'b0;
            smi_prev_q <= 1'b0;
        end else begin
            if (irq_s[1] == irq_s[2]) begin
                irq_lvl_q <= irq_s[2];
            end
            if (nmi_s[1] == nmi_s[2]) begin
                nmi_lvl_q <= nmi_s[2];
            end
            if (smi_s[1] == smi_s[2]) begin
                smi_lvl_q <= smi_s[2];
            end
            nmi_prev_q <= nmi_lvl_q;
            smi_prev_q <= smi_lvl_q;
        end
    end

    // NMI is edge-triggered; a pending edge is held until served.
    logic nmi_pend_q;
    logic nmi_take;
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            nmi_pend_q <= 1'b0;
        end else if (nmi_lvl_q && !nmi_prev_q) begin
            nmi_pend_q <= 1'b1; // Set wins over the clear below.
        end else if (nmi_take) begin
            nmi_pend_q <= 1'b0;
        end
    end

    // --------------------------------------------------------------
    // Exception vector encoder.
    // --------------------------------------------------------------
    // Fixed map from cause bit to vector; reserved numbers never appear.
    function automatic logic [7:0] exc_vector(input logic [4:0] idx);
        logic [7:0] v;
        v = `IED_VEC_PROTECTION;
        case (idx)
            5'd0: v = `IED_VEC_QUOTIENT;
            5'd1: v = `IED_VEC_DEBUG;
            5'd2: v = `IED_VEC_BREAKPOINT;
            5'd3: v = `IED_VEC_OVERFLOW;
            5'd4: v = `IED_VEC_BOUNDS;
            5'd5: v = `IED_VEC_INV_OPCODE;
            5'd6: v = `IED_VEC_NO_COPROC;
            5'd7: v = `IED_VEC_DOUBLE_FAULT;
            5'd8: v = `IED_VEC_INV_TASK_STATE;
            5'd9: v = `IED_VEC_SEG_ABSENT;
            5'd10: v = `IED_VEC_STACK_FAULT;
            5'd11: v = `IED_VEC_PROTECTION;
            5'd12: v = `IED_VEC_PAGING;
            5'd13: v = `IED_VEC_MATH;
            5'd14: v = `IED_VEC_ALIGN;
            5'd15: v = `IED_VEC_MACHINE_CHECK;
            5'd16: v = `IED_VEC_SIMD;
            5'd17: v = `IED_VEC_VIRT;
            default: v = `IED_VEC_PROTECTION;
        endcase
        return v;
    endfunction : exc_vector

    // Lowest-numbered raised cause wins; a generate loop scans the bits.
    logic [EXC_N-1:0] exc_lower; // Bit i set when some cause below i is raised.
    genvar gi;
    generate
        for (gi = 0; gi < EXC_N; gi++) begin : g_pri
            if (gi == 0) begin : g_first
                assign exc_lower[gi] = 1'b0;
            end else begin : g_rest
                assign exc_lower[gi] = exc_lower[gi-1] | exc_req[gi-1];
            end
        end
    endgenerate

    logic [4:0] exc_idx;
    always_comb begin
        exc_idx = 5'd0;
        for (int i = 0; i < EXC_N; i++) begin
            if (exc_req[i] && !exc_lower[i]) begin
                exc_idx = 5'(i);
            end
        end
    end

    // --------------------------------------------------------------
    // Event selection.
    // --------------------------------------------------------------
    // Synchronous exceptions come first, then NMI, then software, then the pin.
    logic idle;
    logic irq_ok;
    logic soft_ok;
    logic any_take;
    assign idle = (state_q == IED_IDLE);
    assign irq_ok = irq_lvl_q && flags_register_q[`IED_FLAG_IE_BIT];
    // Software vectors below 32 or reserved are refused and flagged instead.
    assign soft_ok = soft_int_req && (soft_int_vector >= `IED_VEC_USER_FIRST);
    assign nmi_take = idle && !(|exc_req) && nmi_pend_q;
    assign any_take = idle && ((|exc_req) || nmi_pend_q || soft_ok || irq_ok);

    // Entry read address follows the chosen vector.
    logic [7:0] sel_vec;
    ied_class_t sel_cls;
    always_comb begin
        sel_vec = 8'h00;
        sel_cls = IED_CLS_EXTERNAL_IRQ_PIN;
        if (|exc_req) begin
            sel_vec = exc_vector(exc_idx);
            sel_cls = exc_class;
        end else if (nmi_pend_q) begin
            sel_vec = `IED_VEC_NMI;
        end else if (soft_ok) begin
            sel_vec = soft_int_vector;
        end else if (irq_ok) begin
            sel_vec = external_irq_vector;
        end
    end

    ied_descriptor_table #(
        .ENTRY_W(64),
        .DEPTH(256)
    ) u_table (
        .clk(clk),
        .wr_en(table_wr_en),
        .wr_idx(table_wr_idx),
        .wr_data(table_wr_data),
        .rd_idx(any_take ? sel_vec : vec_q),
        .rd_data(tbl_rd)
    );

    // Gate fields: [15:0] offset low, [31:16] selector, [43:40] type,
    // [46:45] privilege, [63:48] offset high.
    logic [3:0] g_type;
    logic [1:0] g_dpl;
    assign g_type = tbl_rd[43:40];
    assign g_dpl = tbl_rd[46:45];

    // --------------------------------------------------------------
    // Sequencer.
    // --------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_q <= IED_IDLE;
        end else begin
            case (state_q)
                IED_IDLE: begin
                    if (any_take) begin
                        state_q <= IED_FETCH;
                    end else if (handler_return_instruction) begin
                        state_q <= IED_POP_IP;
                    end
                end
                IED_FETCH: state_q <= IED_DECODE;
                IED_DECODE: begin
                    if (g_type == `IED_GATE_TASK) begin
                        state_q <= IED_IDLE;
                    end else if (g_dpl < current_priv) begin
                        state_q <= IED_PUSH_SS;
                    end else begin
                        state_q <= IED_PUSH_FL;
                    end
                end
                IED_PUSH_SS: state_q <= IED_PUSH_SP;
                IED_PUSH_SP: state_q <= IED_PUSH_FL;
                IED_PUSH_FL: state_q <= IED_PUSH_CS;
                IED_PUSH_CS: state_q <= IED_PUSH_IP;
                IED_PUSH_IP: state_q <= err_v_q ? IED_PUSH_ERR : IED_LOAD;
                IED_PUSH_ERR: state_q <= IED_LOAD;
                IED_LOAD: state_q <= IED_IDLE;
                IED_POP_IP: state_q <= IED_POP_CS;
                IED_POP_CS: state_q <= IED_POP_FL;
                IED_POP_FL: state_q <= ret_chg_q ? IED_POP_SP : IED_IDLE;
                IED_POP_SP: state_q <= IED_POP_SS;
                IED_POP_SS: state_q <= IED_IDLE;
                default: state_q <= IED_IDLE;
            endcase
        end
    end

    // Event capture at acceptance; vector, class and error code are sampled, program state is not.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            vec_q <= 8'h00;
            cls_q <= IED_CLS_EXTERNAL_IRQ_PIN;
            err_q <= 32'h0000_0000;
            err_v_q <= 1'b0;
            ret_chg_q <= 1'b0;
        end else if (any_take) begin
            vec_q <= sel_vec;
            cls_q <= sel_cls;
            err_q <= exc_error_code;
            err_v_q <= (|exc_req) && exc_has_error;
        end else if (idle && handler_return_instruction) begin
            ret_chg_q <= (code_selector_q[1:0] != current_priv);
        end
    end

    // Saved state of the interrupted program.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sv_fl_q <= 32'h0000_0000;
            sv_ip_q <= 32'h0000_0000;
            sv_cs_q <= 16'h0000;
            sv_sp_q <= 32'h0000_0000;
            sv_ss_q <= 16'h0000;
            gate_q <= 64'h0000_0000_0000_0000;
            switch_q <= 1'b0;
        end else if (state_q == IED_FETCH) begin
            sv_fl_q <= flags_register_q;
            sv_ip_q <= cur_instruction_pointer;
            sv_cs_q <= cur_code_selector;
            sv_sp_q <= cur_stack_pointer;
            sv_ss_q <= cur_stack_selector;
        end else if (state_q == IED_DECODE) begin
            gate_q <= tbl_rd;
            switch_q <= (g_dpl < current_priv);
        end
    end

    // Stack pointer and selector: switch, decrement per push, increment per pop of pointer, code selector and flags.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            stack_pointer_q <= '0;
            stack_selector_q <= 16'h0000;
        end else if (state_q == IED_FETCH) begin
            stack_pointer_q <= ADDR_W'(cur_stack_pointer);
            stack_selector_q <= cur_stack_selector;
        end else if (state_q == IED_DECODE && g_dpl < current_priv) begin
            stack_pointer_q <= ADDR_W'(priv_stack_pointer);
            stack_selector_q <= priv_stack_selector;
        end else if (push_valid) begin
            stack_pointer_q <= stack_pointer_q - ADDR_W'(4);
        end else if (state_q == IED_POP_SP) begin
            stack_pointer_q <= ADDR_W'(pop_data); // The popped pointer is final, no step after it.
        end else if (state_q == IED_POP_SS) begin
            stack_selector_q <= pop_data[15:0];
        end else if (pop_req) begin
            stack_pointer_q <= stack_pointer_q + ADDR_W'(4);
        end
    end

    // Push data in order: old stack (if switching), flags, selector, pointer, code.
    always_comb begin
        push_valid = 1'b1;
        push_data = 32'h0000_0000;
        case (state_q)
            IED_PUSH_SS: push_data = {16'h0000, sv_ss_q};
            IED_PUSH_SP: push_data = sv_sp_q;
            IED_PUSH_FL: push_data = sv_fl_q;
            IED_PUSH_CS: push_data = {16'h0000, sv_cs_q};
            IED_PUSH_IP: push_data = sv_ip_q;
            IED_PUSH_ERR: push_data = err_q;
            default: push_valid = 1'b0;
        endcase
    end

    // Pops run in reverse order of the pushes.
    assign pop_req = (state_q == IED_POP_IP) || (state_q == IED_POP_CS) || (state_q == IED_POP_FL) ||
                     (state_q == IED_POP_SP) || (state_q == IED_POP_SS);

    // Code selector and pointer: gate on entry, popped values on return.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            code_selector_q <= 16'h0000;
            instruction_pointer_q <= 32'h0000_0000;
        end else if (state_q == IED_LOAD) begin
            code_selector_q <= gate_q[31:16];
            instruction_pointer_q <= {gate_q[63:48], gate_q[15:0]};
        end else if (state_q == IED_POP_IP) begin
            instruction_pointer_q <= pop_data;
        end else if (state_q == IED_POP_CS) begin
            code_selector_q <= pop_data[15:0];
        end
    end

    // Flags register: software load, gate clears, return restores.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            flags_register_q <= `IED_FLAGS_RESET;
        end else if (state_q == IED_LOAD && gate_q[43:40] == `IED_GATE_EXTERNAL_IRQ_PIN) begin
            flags_register_q[`IED_FLAG_IE_BIT] <= 1'b0;
        end else if (state_q == IED_POP_FL) begin
            flags_register_q <= pop_data;
        end else if (flags_wr_en) begin
            flags_register_q <= flags_wr_data;
        end
        // A trap gate takes no branch here, so the flag holds.
    end

    // --------------------------------------------------------------
    // Status outputs.
    // --------------------------------------------------------------
    // Reported vector and class for the event in service.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            taken_vector <= 8'h00;
            taken_class <= IED_CLS_EXTERNAL_IRQ_PIN;
        end else if (state_q == IED_FETCH) begin
            taken_vector <= vec_q;
            taken_class <= cls_q;
        end
    end

    // Task gates hand off to the task switch unit; SYSTEM_MANAGEMENT_INTERRUPT bypasses the table.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            task_switch_req <= 1'b0;
            smm_entry <= 1'b0;
            redirect <= 1'b0;
            reserved_vector_err <= 1'b0;
        end else begin
            task_switch_req <= (state_q == IED_DECODE) && (g_type == `IED_GATE_TASK);
            smm_entry <= smi_lvl_q && !smi_prev_q;
            redirect <= (state_q == IED_LOAD) || (state_q == IED_POP_FL && !ret_chg_q) ||
                        (state_q == IED_POP_SS);
            reserved_vector_err <= idle && soft_int_req && !soft_ok;
        end
    end

    // The pipeline stays halted from acceptance until the sequence ends.
    assign pipeline_halt = !idle || any_take;
    // Task gate check above other types dispatch as procedures.
    // switch_q is kept for visibility of privilege changes on the push path.
    logic unused_ok;
    assign unused_ok = switch_q;
endmodule : ied_dispatch

// File: shared/ied_defines.svh
// Constants for the interrupt and exception dispatch block.
`ifndef IED_DEFINES_SVH
`define IED_DEFINES_SVH
// Fixed vector numbers of the predefined events.
`define IED_VEC_QUOTIENT 8'h00
`define IED_VEC_DEBUG 8'h01
`define IED_VEC_NMI 8'h02
`define IED_VEC_BREAKPOINT 8'h03
`define IED_VEC_OVERFLOW 8'h04
`define IED_VEC_BOUNDS 8'h05
`define IED_VEC_INV_OPCODE 8'h06
`define IED_VEC_NO_COPROC 8'h07
`define IED_VEC_DOUBLE_FAULT 8'h08
`define IED_VEC_INV_TASK_STATE 8'h0A
`define IED_VEC_SEG_ABSENT 8'h0B
`define IED_VEC_STACK_FAULT 8'h0C
`define IED_VEC_PROTECTION 8'h0D
`define IED_VEC_PAGING 8'h0E
`define IED_VEC_MATH 8'h10
`define IED_VEC_ALIGN 8'h11
`define IED_VEC_MACHINE_CHECK 8'h12
`define IED_VEC_SIMD 8'h13
`define IED_VEC_VIRT 8'h14
// First vector open to software and maskable hardware interrupts.
`define IED_VEC_USER_FIRST 8'h20
// Gate type codes held in the access-rights field of a table entry.
`define IED_GATE_TASK 4'h5
`define IED_GATE_EXTERNAL_IRQ_PIN 4'hE
`define IED_GATE_TRAP 4'hF
// Position of the interrupt enable flag in the flags register.
`define IED_FLAG_IE_BIT 9
// Flags register value after reset.
`define IED_FLAGS_RESET 32'h0000_0002
`endif

// File: shared/ied_pkg.sv
// Types shared by the interrupt and exception dispatch block.
package ied_pkg;
    // Class of an event presented by the pipeline.
    typedef enum logic [1:0] {
        IED_CLS_FAULT,
        IED_CLS_TRAP,
        IED_CLS_ABORT,
        IED_CLS_EXTERNAL_IRQ_PIN
    } ied_class_t;
    // Exception causes the pipeline can raise, one bit each.
    typedef enum logic [4:0] {
        IED_EXC_QUOTIENT, IED_EXC_DEBUG, IED_EXC_BREAKPOINT, IED_EXC_OVERFLOW,
        IED_EXC_BOUNDS, IED_EXC_INV_OPCODE, IED_EXC_NO_COPROC, IED_EXC_DOUBLE_FAULT,
        IED_EXC_INV_TASK_STATE, IED_EXC_SEG_ABSENT, IED_EXC_STACK_FAULT, IED_EXC_PROTECTION,
        IED_EXC_PAGING, IED_EXC_MATH, IED_EXC_ALIGN, IED_EXC_MACHINE_CHECK,
        IED_EXC_SIMD, IED_EXC_VIRT
    } ied_exc_t;
endpackage : ied_pkg

// File: verilog/ied_descriptor_table.sv
// Handler descriptor table: 256 entries, registered read port.
`timescale 1ns/1ps
module ied_descriptor_table #(
    parameter int ENTRY_W = 64,
    parameter int DEPTH = 256
) (
    input wire logic clk,
    input wire logic wr_en,
    input wire logic [$clog2(DEPTH)-1:0] wr_idx,
    input wire logic [ENTRY_W-1:0] wr_data,
    input wire logic [$clog2(DEPTH)-1:0] rd_idx,
    output logic [ENTRY_W-1:0] rd_data
);
    // Storage array; contents are undefined until software loads them.
    logic [ENTRY_W-1:0] mem [DEPTH];

    // --------------------------------------------------------------
    // Write and registered read.
    // --------------------------------------------------------------
    // The read data come from a register so the lookup takes one cycle.
    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem[wr_idx] <= wr_data;
        end
        rd_data <= mem[rd_idx];
    end
endmodule : ied_descriptor_table

// File: tb/ied_dispatch_properties.sv
// Port assertions for the dispatch block.
`timescale 1ns/1ps
`include "ied_defines.svh"
module ied_dispatch_properties #(parameter int EXC_N = 18) (
    input wire logic clk, sys_rst, pipeline_halt, smm_entry, task_switch_req, redirect,
    input wire logic reserved_vector_err, soft_int_req, push_valid, pop_req, handler_return_instruction,
    input wire logic [7:0] taken_vector, soft_int_vector,
    input wire logic [EXC_N-1:0] exc_req
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    property p_smm; smm_entry |=> !smm_entry; endproperty
    a_smm: assert property (p_smm) else $error("smm pulse too long");
    property p_task; task_switch_req |=> !task_switch_req; endproperty
    a_task: assert property (p_task) else $error("task pulse too long");
    property p_rsv; pipeline_halt |=> !(taken_vector inside {8'h09, 8'h0F, [8'h15:8'h1F]}); endproperty
    a_rsv: assert property (p_rsv) else $error("reserved vector taken");
    property p_soft; !pipeline_halt && soft_int_req && soft_int_vector < 8'h20 |-> ##[1:4] reserved_vector_err;
    endproperty
    a_soft: assert property (p_soft) else $error("low soft vector not refused");
    property p_push; push_valid |-> pipeline_halt; endproperty
    a_push: assert property (p_push) else $error("push while running");
    property p_halt; $rose(pipeline_halt) && !pop_req |-> ##[2:6] (push_valid || task_switch_req); endproperty
    a_halt: assert property (p_halt) else $error("no dispatch after halt");
    property p_redir; $rose(pipeline_halt) |-> ##[3:16] (redirect || task_switch_req); endproperty
    a_redir: assert property (p_redir) else $error("handler never entered");
    property p_vec0; $rose(pipeline_halt) && exc_req[0] |-> ##2 taken_vector == `IED_VEC_QUOTIENT; endproperty
    a_vec0: assert property (p_vec0) else $error("quotient vector wrong");
    property p_pop; handler_return_instruction && !pipeline_halt |-> ##[0:3] pop_req; endproperty
    a_pop: assert property (p_pop) else $error("return without pops");
    c_redir: cover property (redirect);
    c_task: cover property (task_switch_req);
    c_rsv: cover property (reserved_vector_err);
endmodule : ied_dispatch_properties
bind ied_dispatch ied_dispatch_properties #(.EXC_N(EXC_N)) u_props (.*);

// File: tb/ied_stack_model.sv
// Stack memory behind the push and pop ports.
`timescale 1ns/1ps
module ied_stack_model (
    input wire logic clk,
    input wire logic push_valid,
    input wire logic [31:0] push_data,
    input wire logic pop_req,
    output logic [31:0] pop_data
);
    logic [31:0] stk[$]; // Words pushed and not yet popped.
    initial pop_data = 32'h0000_0000;
    // Top word is offered each cycle; an empty stack shows the inverse, never a stale word.
    always @(posedge clk) begin
        if (push_valid) stk.push_back(push_data);
        if (pop_req && stk.size() != 0) void'(stk.pop_back());
        pop_data <= (stk.size() != 0) ? stk[$] : ~pop_data;
    end
endmodule : ied_stack_model

// File: tb/test_interrupt_exception_dispatch.sv
// Self-checking bench for the dispatch block.
`timescale 1ns/1ps
`include "ied_defines.svh"
module test_interrupt_exception_dispatch;
    import ied_pkg::*;
    logic clk = 0, sys_rst = 1, external_irq_pin = 0, nmi_pin = 0, system_management_interrupt = 0;
    logic soft_int_req = 0, handler_return_instruction = 0, flags_wr_en = 0, table_wr_en = 0, exc_has_error = 0;
    logic [17:0] exc_req = 0;
    logic [7:0] external_irq_vector = 8'h40, soft_int_vector = 0, table_wr_idx = 0, taken_vector;
    logic [1:0] current_priv = 0;
    ied_class_t exc_class = IED_CLS_FAULT, taken_class;
    logic [15:0] cur_code_selector = 16'h0010, cur_stack_selector = 16'h0018, priv_stack_selector = 16'h0020;
    logic [15:0] stack_selector_q, code_selector_q;
    logic [31:0] cur_instruction_pointer = 32'h0000_5000, cur_stack_pointer = 32'h0000_8000;
    logic [31:0] priv_stack_pointer = 32'h0000_9000, exc_error_code = 0, flags_wr_data = 0, pop_data, push_data;
    logic [31:0] stack_pointer_q, instruction_pointer_q, flags_register_q;
    logic [63:0] table_wr_data = 0;
    logic pipeline_halt, task_switch_req, smm_entry, push_valid, pop_req, redirect, reserved_vector_err;
    logic [3:0] seen; // Which completion pulse ended the last wait.
    int failures = 0, n_compared = 0;
    byte unsigned vec[18] = '{0, 1, 3, 4, 5, 6, 7, 8, 10, 11, 12, 13, 14, 16, 17, 18, 19, 20};
    always #2.5 clk = ~clk;
    ied_dispatch i_ied_dispatch (.*);
    ied_stack_model i_ied_stack_model (.*);
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task conclude;
        if (failures == 0 && n_compared > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : conclude
    task tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick
    task set_flags(input logic [31:0] v);
        flags_wr_en = 1; flags_wr_data = v; tick(1); flags_wr_en = 0;
    endtask : set_flags
    // Bounded wait for a completion pulse; requests drop once taken so none fires twice.
    task wait_done;
        int k;
        k = 0;
        while (!(redirect || task_switch_req || smm_entry || reserved_vector_err) && k < 60) begin
            if (pipeline_halt) {external_irq_pin, nmi_pin} = 2'b00;
            tick(1); k++;
        end
        seen = {redirect, task_switch_req, smm_entry, reserved_vector_err};
        {external_irq_pin, nmi_pin, system_management_interrupt} = 3'b000;
        while (pipeline_halt && k < 90) begin tick(1); k++; end
        tick(1);
    endtask : wait_done
    initial begin
        #20us; failures++; conclude();
    end
    initial begin
        tick(16); sys_rst = 0;
        chk(flags_register_q, `IED_FLAGS_RESET);
        for (int v = 0; v < 256; v++) begin
            table_wr_en = 1; table_wr_idx = v[7:0];
            table_wr_data = {16'h0000, 4'h8, (v == 64) ? `IED_GATE_TRAP : (v == 48) ? `IED_GATE_TASK : `IED_GATE_EXTERNAL_IRQ_PIN,
                8'h00, 16'h0008, 8'h10, v[7:0]};
            tick(1);
        end
        table_wr_en = 0;
        foreach (vec[i]) begin
            set_flags(32'h0000_0202);
            exc_req[i] = 1; tick(1); exc_req = 0;
            wait_done();
            chk(seen, 4'b1000);
            chk(taken_vector, vec[i]);
            chk(instruction_pointer_q, {16'h0000, 8'h10, vec[i]});
            chk(flags_register_q[9], 0);
        end
        chk(i_ied_stack_model.stk[$], cur_instruction_pointer);
        chk(i_ied_stack_model.stk[$-2], 32'h0000_0202);
        set_flags(32'h0000_0002); external_irq_pin = 1; tick(12);
        chk(pipeline_halt, 0);
        set_flags(32'h0000_0202); wait_done();
        chk(taken_vector, 8'h40);
        chk(taken_class, IED_CLS_EXTERNAL_IRQ_PIN);
        chk(flags_register_q[9], 1);
        handler_return_instruction = 1; tick(1); handler_return_instruction = 0; wait_done();
        chk(instruction_pointer_q, cur_instruction_pointer);
        chk(code_selector_q, cur_code_selector);
        chk(stack_pointer_q, cur_stack_pointer);
        soft_int_vector = 8'h05; soft_int_req = 1; tick(1); soft_int_req = 0; wait_done();
        chk(seen, 4'b0001);
        soft_int_vector = 8'h30; soft_int_req = 1; tick(1); soft_int_req = 0; wait_done();
        chk(seen, 4'b0100);
        nmi_pin = 1; wait_done();
        chk(taken_vector, `IED_VEC_NMI);
        system_management_interrupt = 1; wait_done();
        chk(seen, 4'b0010);
        conclude();
    end
endmodule : test_interrupt_exception_dispatch
